// File: hdl/parc_defs.svh
`ifndef PARC_DEFS_SVH
`define PARC_DEFS_SVH
// Register offsets.
`define PARC_CFG_ADDR 10'h3AA
// Field positions inside the configuration register.
`define PARC_SRC_BIT 3
`define PARC_MODE_LSB 0
`define PARC_MODE_MSB 2
`define PARC_CFG_RESET 8'h00
// Ramp step time and clock period in picoseconds.
`define PARC_STEP_PS 2400
`define PARC_CLK_PS 4000
// Values that select the high power mode.
`define PARC_HP_BIAS 6'h3F
`define PARC_HP_BRIDGE 6'h15
`endif

// File: hdl/parc_pkg.sv
package parc_pkg;
  typedef enum logic [2:0] {
    PARC_MODE_SWITCH,
    PARC_MODE_SOURCE,
    PARC_MODE_SINK,
    PARC_MODE_SOURCE_OPEN,
    PARC_MODE_SINK_OPEN,
    PARC_MODE_SERVO_POS,
    PARC_MODE_SERVO_NEG,
    PARC_MODE_RESERVED
  } parc_mode_t;
  typedef enum logic [2:0] {
    PARC_PIN_UNUSED,
    PARC_PIN_SOURCE,
    PARC_PIN_SINK,
    PARC_PIN_SERVO_POS,
    PARC_PIN_SERVO_NEG
  } parc_pin_t;
endpackage : parc_pkg

// File: hdl/parc_tick.sv
`timescale 1ns/1ps
`default_nettype none
`include "parc_defs.svh"
// Pulses at an average spacing of 2^exponent steps of 2.4 ns, or every clock at exponent 0; restarts whenever clear is high.
module parc_tick (
  input wire logic clk,
  input wire logic srst,
  input wire logic clear,
  input wire logic [3:0] exponent,
  output logic tick
);
  logic [27:0] acc;
  logic [27:0] period;
  logic [27:0] sum;

  // The longest tick spacing, 2^15 steps of 2.4 ns, still fits in 28 bits of picoseconds.
  assign period = 28'(`PARC_STEP_PS) << exponent;
  assign sum = 28'(acc + 28'(`PARC_CLK_PS));

  // Picosecond accumulator: the clock is slower than one step, so above exponent 0 tick spacing alternates
  // between whole cycles while the long-run rate matches the nominal step time.
  always_ff @(posedge clk) begin
    if (srst || clear) begin
      acc <= 28'h0;
      tick <= 1'b0;
    end else if (sum >= period) begin
      tick <= 1'b1; // [R4]
      // Saturate when a tick is shorter than a clock, since only one code moves per cycle.
      acc <= (28'(sum - period) >= period) ? period : 28'(sum - period);
    end else begin
      acc <= sum;
      tick <= 1'b0;
    end
  end
endmodule : parc_tick
`default_nettype wire

// File: hdl/parc_ramp_ctrl.sv
//Function
//[R1] Ramp power up on TX entry; then start packet
//[R2] By default switch amplifier off immediately
//[R3] Ramp-down select ramps down at same rate
//[R4] Ramp time is 2^rate times 2.4ns times power; rate 0 gives one code per 4 ns clock
//[R5] Ramp steps are linear in decibels
//[R6] Power word sets output, about 2 dB/code
//[R7] Host programs 63 and 21 for high power
//[R8] Manual mode follows host bias enable bit
//[R9] Auto mode enables external amp during TX
//[R10] Host leaves bias enable alone in auto
//[R11] Source bit picks resistor or internal reference
//[R12] Modes 0-2 close switch; pin unused/source/sink
//[R13] Modes 3,4 source/sink with switch open
//[R14] Mode 5 closes switch, positive servo
//[R15] Mode 6 negative servo polarity
//[R16] Mode 7 reserved; disabled means all off
`timescale 1ns/1ps
`default_nettype none
`include "parc_defs.svh"
module parc_ramp_ctrl (
  input wire logic clk,
  input wire logic srst,
  input wire logic cfg_wr,
  input wire logic [9:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  input wire logic [5:0] output_power_word,
  input wire logic [3:0] ramp_rate_exponent,
  input wire logic ramp_down_select,
  input wire logic ext_auto_enable,
  input wire logic ext_bias_enable,
  input wire logic [5:0] amp_bias_level,
  input wire logic [5:0] bridge_bias_level,
  input wire logic tx_active,
  input wire logic tx_done,
  output logic [5:0] amp_power,
  output logic amp_on,
  output logic ramp_done,
  output logic high_power,
  output logic supply_switch_closed,
  output parc_pkg::parc_pin_t bias_pin_function,
  output logic bias_ref_internal,
  output logic ramp_busy
);
  import parc_pkg::*;

  typedef enum logic [2:0] {
    PARC_ST_OFF,
    PARC_ST_UP,
    PARC_ST_ON,
    PARC_ST_DOWN
  } parc_state_t;

  parc_state_t state;
  logic [7:0] cfg;
  logic step;
  logic tx_prev;
  logic leave;
  logic ext_en;
  parc_mode_t mode;

  // Configuration register: bias mode and DAC reference source.
  always_ff @(posedge clk) begin
    if (srst) begin
      cfg <= `PARC_CFG_RESET;
    end else if (cfg_wr && cfg_addr == `PARC_CFG_ADDR) begin
      cfg <= cfg_wdata;
    end
  end

  // Readback shows the stored configuration; other addresses read zero.
  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_rdata <= 8'h00;
    end else begin
      cfg_rdata <= (cfg_addr == `PARC_CFG_ADDR) ? cfg : 8'h00;
    end
  end

  assign mode = parc_mode_t'(cfg[`PARC_MODE_MSB:`PARC_MODE_LSB]);

  // One code per tick, so a ramp lasts 2^rate x 2.4 ns for each code of the power word, or one 4 ns clock per code at rate 0.
  parc_tick u_tick (
    .clk(clk),
    .srst(srst),
    .clear(state == PARC_ST_OFF || state == PARC_ST_ON),
    .exponent(ramp_rate_exponent), // [R4]
    .tick(step)
  );

  // Previous TX level, so entry and exit are seen as edges.
  always_ff @(posedge clk) begin
    if (srst) begin
      tx_prev <= 1'b0;
    end else begin
      tx_prev <= tx_active;
    end
  end
  assign leave = (tx_prev && !tx_active) || tx_done;

  // Ramp sequencer: one code per step; codes are dB-spaced, so the profile is linear in dB.
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= PARC_ST_OFF;
      amp_power <= 6'h00;
      amp_on <= 1'b0;
      ramp_done <= 1'b0;
    end else begin
      case (state)
        PARC_ST_OFF: begin
          ramp_done <= 1'b0;
          if (tx_active && !tx_prev) begin
            state <= PARC_ST_UP; // [R1]
            amp_power <= 6'h00;
            amp_on <= 1'b1;
          end
        end
        PARC_ST_UP: begin
          if (leave) begin
            state <= PARC_ST_OFF;
            amp_on <= 1'b0;
            amp_power <= 6'h00;
          end else if (amp_power >= output_power_word) begin
            state <= PARC_ST_ON;
            ramp_done <= 1'b1; // [R1]
          end else if (step) begin
            amp_power <= 6'(amp_power + 6'h01); // [R5]
          end
        end
        PARC_ST_ON: begin
          amp_power <= output_power_word; // [R6]
          if (leave && ramp_down_select) begin
            state <= PARC_ST_DOWN; // [R3]
            ramp_done <= 1'b0;
          end else if (leave) begin
            state <= PARC_ST_OFF; // [R2]
            amp_on <= 1'b0;
            amp_power <= 6'h00;
            ramp_done <= 1'b0;
          end
        end
        PARC_ST_DOWN: begin
          if (amp_power == 6'h00) begin
            state <= PARC_ST_OFF;
            amp_on <= 1'b0;
          end else if (step) begin
            amp_power <= 6'(amp_power - 6'h01); // [R3]
          end
        end
        default: begin
          state <= PARC_ST_OFF;
          amp_on <= 1'b0;
          amp_power <= 6'h00;
          ramp_done <= 1'b0;
        end
      endcase
    end
  end

  // Automatic enable tracks the TX state; manual follows the host bit.
  assign ext_en = ext_auto_enable ? tx_active : ext_bias_enable; // [R8] [R9]

  // Switch and pin function per bias mode; disabled or reserved means all off.
  always_ff @(posedge clk) begin
    if (srst) begin
      supply_switch_closed <= 1'b0;
      bias_pin_function <= PARC_PIN_UNUSED;
    end else if (!ext_en) begin
      supply_switch_closed <= 1'b0; // [R16]
      bias_pin_function <= PARC_PIN_UNUSED;
    end else begin
      case (mode)
        PARC_MODE_SWITCH: begin
          supply_switch_closed <= 1'b1; // [R12]
          bias_pin_function <= PARC_PIN_UNUSED;
        end
        PARC_MODE_SOURCE: begin
          supply_switch_closed <= 1'b1; // [R12]
          bias_pin_function <= PARC_PIN_SOURCE;
        end
        PARC_MODE_SINK: begin
          supply_switch_closed <= 1'b1; // [R12]
          bias_pin_function <= PARC_PIN_SINK;
        end
        PARC_MODE_SOURCE_OPEN: begin
          supply_switch_closed <= 1'b0; // [R13]
          bias_pin_function <= PARC_PIN_SOURCE;
        end
        PARC_MODE_SINK_OPEN: begin
          supply_switch_closed <= 1'b0; // [R13]
          bias_pin_function <= PARC_PIN_SINK;
        end
        PARC_MODE_SERVO_POS: begin
          supply_switch_closed <= 1'b1; // [R14]
          bias_pin_function <= PARC_PIN_SERVO_POS;
        end
        PARC_MODE_SERVO_NEG: begin
          supply_switch_closed <= 1'b1; // [R15]
          bias_pin_function <= PARC_PIN_SERVO_NEG;
        end
        default: begin
          supply_switch_closed <= 1'b0; // [R16]
          bias_pin_function <= PARC_PIN_UNUSED;
        end
      endcase
    end
  end

  // Status and high power decode; the host owns the two bias levels.
  always_ff @(posedge clk) begin
    if (srst) begin
      bias_ref_internal <= 1'b0;
      high_power <= 1'b0;
      ramp_busy <= 1'b0;
    end else begin
      bias_ref_internal <= cfg[`PARC_SRC_BIT]; // [R11]
      high_power <= (amp_bias_level == `PARC_HP_BIAS) &&
                    (bridge_bias_level == `PARC_HP_BRIDGE); // [R7]
      ramp_busy <= (state == PARC_ST_UP) || (state == PARC_ST_DOWN);
    end
  end

  // Switch, pin, ramp and reference source checks; registered outputs answer one cycle after the cause.
  chk_switch_off: assert property (@(posedge clk) disable iff (srst) // [R16]
    !ext_en |=> !supply_switch_closed) else $error("switch closed while disabled");
  chk_auto_enable: assert property (@(posedge clk) disable iff (srst) // [R9]
    (ext_auto_enable && tx_active && mode != PARC_MODE_SOURCE_OPEN &&
    mode != PARC_MODE_SINK_OPEN && mode != PARC_MODE_RESERVED) |=> supply_switch_closed)
    else $error("auto enable missed");
  chk_open_modes: assert property (@(posedge clk) disable iff (srst) // [R13]
    (mode == PARC_MODE_SOURCE_OPEN || mode == PARC_MODE_SINK_OPEN) |=> !supply_switch_closed)
    else $error("switch closed in open mode");
  chk_servo_neg: assert property (@(posedge clk) disable iff (srst) // [R15]
    (ext_en && mode == PARC_MODE_SERVO_NEG) |=> bias_pin_function == PARC_PIN_SERVO_NEG)
    else $error("servo polarity wrong");
  chk_servo_pos: assert property (@(posedge clk) disable iff (srst) // [R14]
    (ext_en && mode == PARC_MODE_SERVO_POS) |=> supply_switch_closed)
    else $error("servo switch open");
  chk_fast_off: assert property (@(posedge clk) disable iff (srst) // [R2]
    (state == PARC_ST_ON && leave && !ramp_down_select) |=> !amp_on && amp_power == 6'h00)
    else $error("amplifier not off");
  chk_ramp_down: assert property (@(posedge clk) disable iff (srst) // [R3]
    (state == PARC_ST_ON && leave && ramp_down_select) |=> amp_on && state == PARC_ST_DOWN)
    else $error("ramp down skipped");
  chk_monotone_up: assert property (@(posedge clk) disable iff (srst) // [R5]
    (state == PARC_ST_UP && $past(state) == PARC_ST_UP) |-> amp_power >= $past(amp_power))
    else $error("ramp not monotone");
  chk_done_at_level: assert property (@(posedge clk) disable iff (srst) // [R1]
    $rose(ramp_done) |-> amp_power >= output_power_word)
    else $error("ramp done early");
  chk_src_bit: assert property (@(posedge clk) disable iff (srst) // [R11]
    1'b1 |=> bias_ref_internal == $past(cfg[`PARC_SRC_BIT]))
    else $error("reference source wrong");

  // Enable, pin function and decode checks.
  chk_manual_enable: assert property (@(posedge clk) disable iff (srst) // [R8]
    (!ext_auto_enable && ext_bias_enable && mode == PARC_MODE_SWITCH) |=> supply_switch_closed)
    else $error("manual enable ignored");
  chk_auto_off: assert property (@(posedge clk) disable iff (srst) // [R9]
    (ext_auto_enable && !tx_active) |=> !supply_switch_closed)
    else $error("auto disable missed");
  chk_pin_idle: assert property (@(posedge clk) disable iff (srst) // [R16]
    !ext_en |=> bias_pin_function == PARC_PIN_UNUSED)
    else $error("pin used while disabled");
  chk_pin_source: assert property (@(posedge clk) disable iff (srst) // [R12]
    (ext_en && mode == PARC_MODE_SOURCE) |=> bias_pin_function == PARC_PIN_SOURCE)
    else $error("pin not a source");
  chk_pin_sink: assert property (@(posedge clk) disable iff (srst) // [R12]
    (ext_en && mode == PARC_MODE_SINK) |=> bias_pin_function == PARC_PIN_SINK)
    else $error("pin not a sink");
  chk_open_source: assert property (@(posedge clk) disable iff (srst) // [R13]
    (ext_en && mode == PARC_MODE_SOURCE_OPEN) |=> bias_pin_function == PARC_PIN_SOURCE)
    else $error("open mode pin not a source");
  chk_open_sink: assert property (@(posedge clk) disable iff (srst) // [R13]
    (ext_en && mode == PARC_MODE_SINK_OPEN) |=> bias_pin_function == PARC_PIN_SINK)
    else $error("open mode pin not a sink");
  chk_high_power: assert property (@(posedge clk) disable iff (srst) // [R7]
    (amp_bias_level == `PARC_HP_BIAS && bridge_bias_level == `PARC_HP_BRIDGE) |=> high_power)
    else $error("high power not decoded");

  // Ramp sequencing and readback checks.
  chk_no_early_done: assert property (@(posedge clk) disable iff (srst) // [R1]
    state == PARC_ST_UP |-> !ramp_done)
    else $error("done during ramp up");
  chk_up_exit_off: assert property (@(posedge clk) disable iff (srst) // [R2]
    (state == PARC_ST_UP && leave) |=> !amp_on && amp_power == 6'h00)
    else $error("exit during ramp not off");
  chk_down_holds: assert property (@(posedge clk) disable iff (srst) // [R3]
    (state == PARC_ST_DOWN && amp_power != 6'h00) |=> amp_on)
    else $error("ramp down cut short");
  chk_down_ends: assert property (@(posedge clk) disable iff (srst) // [R3]
    (state == PARC_ST_DOWN && amp_power == 6'h00) |=> !amp_on && state == PARC_ST_OFF)
    else $error("ramp down not ended");
  chk_monotone_down: assert property (@(posedge clk) disable iff (srst) // [R5]
    (state == PARC_ST_DOWN && $past(state) == PARC_ST_DOWN) |-> amp_power <= $past(amp_power))
    else $error("ramp down not monotone");
  chk_level_held: assert property (@(posedge clk) disable iff (srst) // [R6]
    (state == PARC_ST_ON && $past(state) == PARC_ST_ON) |-> amp_power == $past(output_power_word))
    else $error("power word not applied");
  chk_busy_flag: assert property (@(posedge clk) disable iff (srst)
    (state == PARC_ST_UP || state == PARC_ST_DOWN) |=> ramp_busy)
    else $error("busy missing during ramp");
  chk_rdata_other: assert property (@(posedge clk) disable iff (srst)
    cfg_addr != `PARC_CFG_ADDR |=> cfg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule : parc_ramp_ctrl
`default_nettype wire

// File: verif/parc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host side bias fields; only the exact pair of codes may select high power.
module parc_host_model (
  input wire logic hp_req,
  output logic [5:0] amp_bias_level,
  output logic [5:0] bridge_bias_level
);
  // The low setting misses both codes by one, so a loose decode is caught.
  assign amp_bias_level = hp_req ? 6'h3F : 6'h3E;
  assign bridge_bias_level = hp_req ? 6'h15 : 6'h14;
endmodule : parc_host_model
`default_nettype wire

// File: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import parc_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic cfg_wr = 1'b0;
  logic [9:0] cfg_addr = 10'h3AA;
  logic [7:0] cfg_wdata = 8'h00;
  logic [5:0] pwr = 6'h05;
  logic [3:0] rexp = 4'h2;
  logic rdsel = 1'b0, auto_en = 1'b0, hp_req = 1'b0, en_req = 1'b0;
  logic tx_active = 1'b0, tx_done = 1'b0;
  logic [5:0] abl, bbl, amp_power;
  logic [7:0] cfg_rdata;
  logic amp_on, ramp_done, high_power, sw, ref_int, busy;
  parc_pin_t pin;
  logic [7:0] pin_exp [8] = '{8'h00, 8'h01, 8'h02, 8'h01, 8'h02, 8'h03, 8'h04, 8'h00};
  int n_fail = 0;
  int cmp_count = 0;
  int n;
  // Free running clock at 250 MHz.
  always #2 clk = ~clk;
  parc_host_model i_host (.hp_req(hp_req), .amp_bias_level(abl), .bridge_bias_level(bbl));
  parc_ramp_ctrl i_dut (.clk(clk), .srst(srst), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .output_power_word(pwr),
    .ramp_rate_exponent(rexp), .ramp_down_select(rdsel), .ext_auto_enable(auto_en),
    .ext_bias_enable(en_req), .amp_bias_level(abl), .bridge_bias_level(bbl),
    .tx_active(tx_active), .tx_done(tx_done), .amp_power(amp_power), .amp_on(amp_on),
    .ramp_done(ramp_done), .high_power(high_power), .supply_switch_closed(sw),
    .bias_pin_function(pin), .bias_ref_internal(ref_int), .ramp_busy(busy));
  // Compares a settled output value.
  task automatic chk_out(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_out
  // Compares a cycle count against an allowed window.
  task automatic chk_time(input string name, input int lo, input int hi, input int got);
    cmp_count++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("BAD %s expected %0d to %0d seen %0d", name, lo, hi, got);
    end
  endtask : chk_time
  // Readback has one cycle of latency, so the address is held one full cycle.
  task automatic chk_reg(input logic [9:0] addr, input logic [7:0] exp);
    @(negedge clk);
    cfg_addr = addr;
    @(negedge clk);
    chk_out("cfg_rdata", exp, cfg_rdata);
    cfg_addr = 10'h3AA;
  endtask : chk_reg
  // One write strobe, dropped at the next falling edge.
  task automatic wr(input logic [9:0] addr, input logic [7:0] data);
    @(negedge clk);
    cfg_wr = 1'b1;
    cfg_addr = addr;
    cfg_wdata = data;
    @(negedge clk);
    cfg_wr = 1'b0;
    cfg_addr = 10'h3AA;
  endtask : wr
  // Waits for ramp_done under a bound and counts the cycles taken.
  task automatic wait_done();
    for (n = 0; n < 200 && ramp_done !== 1'b1; n++) @(negedge clk);
  endtask : wait_done
  // Single place where the run ends.
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run
  // A hang costs far more than the hundred or so cycles the sequence needs.
  initial begin
    #20000;
    n_fail++;
    complete_run();
  end
  // Main sequence.
  initial begin
    repeat (3) @(negedge clk);
    srst = 1'b0;
    chk_reg(10'h3AA, 8'h00);
    chk_out("switch", 8'h00, {7'h00, sw});
    wr(10'h3AA, 8'hA9);
    chk_reg(10'h3AA, 8'hA9);
    wr(10'h3AB, 8'h55);
    chk_reg(10'h3AA, 8'hA9);
    chk_reg(10'h3AB, 8'h00);
    en_req = 1'b1;
    for (int m = 0; m < 8; m++) begin
      wr(10'h3AA, {4'h0, m[0], m[2:0]});
      repeat (2) @(negedge clk);
      chk_out("switch", 8'((8'h67 >> m) & 8'h01), {7'h00, sw});
      chk_out("pin", pin_exp[m], {5'h00, pin});
      chk_out("ref_int", {7'h00, m[0]}, {7'h00, ref_int});
    end
    wr(10'h3AA, 8'h01);
    en_req = 1'b0;
    repeat (2) @(negedge clk);
    chk_out("switch", 8'h00, {7'h00, sw});
    chk_out("pin", 8'h00, {5'h00, pin});
    hp_req = 1'b1;
    repeat (2) @(negedge clk);
    chk_out("high_power", 8'h01, {7'h00, high_power});
    hp_req = 1'b0;
    repeat (2) @(negedge clk);
    chk_out("high_power", 8'h00, {7'h00, high_power});
    // Automatic control owns the enable from here; the host bit stays low.
    auto_en = 1'b1;
    tx_active = 1'b1;
    repeat (2) @(negedge clk);
    chk_out("ramp_done", 8'h00, {7'h00, ramp_done});
    chk_out("busy", 8'h01, {7'h00, busy});
    // Four steps of 2.4 ns per code and five codes make twelve cycles, plus pipeline.
    wait_done();
    chk_time("ramp_up", 11, 15, n);
    chk_out("power", {2'b00, pwr}, {2'b00, amp_power});
    chk_out("switch", 8'h01, {7'h00, sw});
    tx_done = 1'b1;
    @(negedge clk);
    tx_done = 1'b0;
    chk_out("amp_on", 8'h00, {7'h00, amp_on});
    tx_active = 1'b0;
    repeat (2) @(negedge clk);
    chk_out("switch", 8'h00, {7'h00, sw});
    rdsel = 1'b1;
    tx_active = 1'b1;
    wait_done();
    tx_active = 1'b0;
    // Busy is registered from the state, so it shows one cycle after the ramp begins.
    repeat (2) @(negedge clk);
    chk_out("busy", 8'h01, {7'h00, busy});
    chk_out("amp_on", 8'h01, {7'h00, amp_on});
    for (n = 2; n < 200 && amp_on !== 1'b0; n++) @(negedge clk);
    chk_time("ramp_down", 12, 16, n);
    chk_out("power", 8'h00, {2'b00, amp_power});
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
